// *** verilog/tsi_defs.vh ***
// Constants for the transport status indicator block
`ifndef TSI_DEFS_VH
`define TSI_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TSI_CTRL_ADDR 8'h00
`define TSI_STAT_ADDR 8'h04
`define TSI_LAMP_ADDR 8'h08
`define TSI_CMD_ADDR 8'h0C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TSI_CTRL_ONLINE 0
`define TSI_CTRL_SETUP 1
`define TSI_CTRL_BW_LIMIT 2
`define TSI_CTRL_VARISPEED 3
`define TSI_CTRL_MCODE_LO 4
`define TSI_CTRL_MCODE_HI 5
`define TSI_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// Command register fields (write one, self clear)
// ----------------------------------------
`define TSI_CMD_CUE 0
`define TSI_CMD_REWIND 1
`define TSI_CMD_MENU_BACK 2

// ----------------------------------------
// Code types
// ----------------------------------------
`define TSI_CODE_30 2'h0
`define TSI_CODE_DROP 2'h1
`define TSI_CODE_25 2'h2
`define TSI_CODE_24 2'h3

// ----------------------------------------
// Speeds
// ----------------------------------------
`define TSI_SPEED_HIGH 2'h0
`define TSI_SPEED_MED 2'h1
`define TSI_SPEED_LOW 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSI_CLK_HZ 25000000
`define TSI_LOCK_QUAL_MS 1000
`define TSI_LOCK_QUAL_CYC ((`TSI_CLK_HZ / 1000) * `TSI_LOCK_QUAL_MS)
`define TSI_FLASH_MS 250
`define TSI_FLASH_CYC ((`TSI_CLK_HZ / 1000) * `TSI_FLASH_MS)
`define TSI_RESOLVE_SUBFRAMES 8'h19

`endif

// *** verilog/tsi_status.v ***
// Transport status indicators with AXI4-Lite register access
// Operation
// RQ1: Online lamp lit: accept commands and drive capstan servo to synchronize.
// RQ2: Online lamp dark: release capstan, transport runs on its own servo.
// RQ3: Offline, cue key and shifted keys still command the transport.
// RQ4: Record tally lit exactly while transport reports recording.
// RQ5: Rehearse tally lit exactly while transport is in rehearse.
// RQ6: Lock lamp only when playing and code synchronized to master.
// RQ7: Lock condition also shows letter L in offset error field.
// RQ8: Lock qualified stable about one second before lamp lights.
// RQ9: Video or digital tape transports: lock, then hand back to internal servo.
// RQ10: Lock and resolve stay lit while locked and within 25 subframes.
// RQ11: Resolve lamp when playing and within 25 hundredths of a frame.
// RQ12: Cue to sync point works only offline, ignored online.
// RQ13: Shift with cue key commands rewind.
// RQ14: In setup the cue key steps menu back one item.
// RQ15: Exactly one code type lamp steady for tape code type.
// RQ16: Master code type lamp flashes when it differs from tape type.
// RQ17: Remote lamp steady in remote, flashing when set to local; code keeps it dark while tp_serial_rl is low.
// RQ18: Bandwidth limit lamp lit while bandwidth limit is selected.
// RQ19: Varispeed lamp lit while synchronizing in varispeed mode.
// RQ20: Three speed lamps show nominal tape speed, one per speed.
// RQ21: Film and vertical interval code lamps show option cards present.
// RQ22: All flashing lamps share one counter-based flash timebase.
// RQ23: Lock timer restarts on raw lock drop; lamp clears at once.
`timescale 1ns/1ps
`default_nettype none
`include "tsi_defs.vh"

module tsi_status #(
	parameter LOCK_QUAL_CYC = `TSI_LOCK_QUAL_CYC,
	parameter FLASH_CYC = `TSI_FLASH_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire tp_recording,
	input wire tp_rehearse,
	input wire tp_playing,
	input wire tp_code_sync,
	input wire [7:0] tp_pos_err,
	input wire tp_video_type,
	input wire [1:0] tp_code_type,
	input wire tp_serial_rl,
	input wire tp_remote,
	input wire [1:0] tp_speed,
	input wire film_card,
	input wire vitc_card,
	input wire shift_key,
	input wire cue_key,
	output reg online_lamp,
	output reg capstan_ctrl,
	output reg servo_release,
	output reg record_tally,
	output reg rehearse_tally,
	output reg lock_lamp,
	output reg err_show_l,
	output reg resolve_lamp,
	output reg [3:0] code_lamps,
	output reg remote_local_indicator,
	output reg bandwidth_limit_indicator,
	output reg varispeed_indicator,
	output reg [2:0] speed_lamps,
	output reg film_lamp,
	output reg vitc_lamp,
	output reg cue_cmd,
	output reg rewind_cmd,
	output reg menu_back
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam NIN = 23;
	wire [NIN-1:0] raw_in;
	reg [NIN-1:0] s1_reg;
	reg [NIN-1:0] s2_reg;
	assign raw_in = {tp_recording, tp_rehearse, tp_playing, tp_code_sync, tp_pos_err,
		tp_video_type, tp_code_type, tp_serial_rl, tp_remote, tp_speed, film_card,
		vitc_card, shift_key, cue_key};

	// Two stages on every pin input
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= {NIN{1'b0}};
			s2_reg <= {NIN{1'b0}};
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
		end
	end

	wire recording_s = s2_reg[22];
	wire rehearse_s = s2_reg[21];
	wire play_s = s2_reg[20];
	wire csync_s = s2_reg[19];
	wire [7:0] perr_s = s2_reg[18:11];
	wire video_s = s2_reg[10];
	wire [1:0] ctype_s = s2_reg[9:8];
	wire serrl_s = s2_reg[7];
	wire remote_s = s2_reg[6];
	wire [1:0] speed_s = s2_reg[5:4];
	wire film_s = s2_reg[3];
	wire vitc_s = s2_reg[2];
	wire shift_s = s2_reg[1];
	wire cue_s = s2_reg[0];

	// ----------------------------------------
	// Register file and AXI4-Lite slave
	// ----------------------------------------
	reg [31:0] ctrl_reg;
	reg aw_got_reg;
	reg w_got_reg;
	reg [7:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;
	reg [2:0] sw_cmd_reg;
	reg cue_prev_reg;

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;

	// Byte-lane merge of write data
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = data[i*8 +: 8];
				end
			end
		end
	endfunction

	// Map a two-bit code onto a one-hot lamp group
	function [3:0] onehot;
		input [1:0] sel;
		begin
			onehot = 4'h1 << sel;
		end
	endfunction

	// Status and lamp readback words
	wire [31:0] stat_word = {19'h0, video_s, speed_s, ctype_s, film_s, vitc_s, remote_s,
		serrl_s, csync_s, play_s, rehearse_s, recording_s};
	wire [31:0] lamp_word = {9'h000, menu_back, rewind_cmd, cue_cmd, vitc_lamp, film_lamp,
		speed_lamps, varispeed_indicator, bandwidth_limit_indicator,
		remote_local_indicator, code_lamps, resolve_lamp, err_show_l, lock_lamp,
		rehearse_tally, record_tally, servo_release, capstan_ctrl, online_lamp};

	// Write channel capture and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			ctrl_reg <= `TSI_CTRL_RESET;
			sw_cmd_reg <= 3'h0;
		end else begin
			sw_cmd_reg <= 3'h0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= 2'h0;
				case (awaddr_reg[7:2])
					6'h00: begin
						ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
					end
					6'h03: begin
						if (wstrb_reg[0]) begin
							sw_cmd_reg <= wdata_reg[2:0];
						end
					end
					6'h01, 6'h02: begin
						bresp_reg <= 2'h0;
					end
					default: begin
						bresp_reg <= 2'h2;
					end
				endcase
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= 2'h0;
			case (s_axi_araddr[7:2])
				6'h00: rdata_reg <= ctrl_reg;
				6'h01: rdata_reg <= stat_word;
				6'h02: rdata_reg <= lamp_word;
				6'h03: rdata_reg <= 32'h0000_0000;
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= 2'h2;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	wire online = ctrl_reg[`TSI_CTRL_ONLINE];
	wire setup = ctrl_reg[`TSI_CTRL_SETUP];
	wire [1:0] mcode = ctrl_reg[`TSI_CTRL_MCODE_HI:`TSI_CTRL_MCODE_LO];
	// Speed code as one-hot, top bit unused
	wire [3:0] speed_oh = onehot(speed_s);

	// ----------------------------------------
	// Flash timebase and lock qualification
	// ----------------------------------------
	reg [23:0] flash_cnt_reg;
	reg flash_reg;
	reg [24:0] qual_cnt_reg;
	reg qualified_reg;
	reg held_reg;
	wire raw_lock = play_s && csync_s;
	wire in_window = perr_s <= `TSI_RESOLVE_SUBFRAMES;
	wire lock_now = raw_lock && (qualified_reg || held_reg) && in_window;

	// Common blink source for every flashing lamp
	always @(posedge aclk) begin
		if (!aresetn) begin
			flash_cnt_reg <= 24'h000000;
			flash_reg <= 1'b0;
		end else if (flash_cnt_reg == FLASH_CYC - 1) begin
			flash_cnt_reg <= 24'h000000; // RQ22
			flash_reg <= !flash_reg;
		end else begin
			flash_cnt_reg <= flash_cnt_reg + 24'h000001;
		end
	end

	// Stability timer on the raw lock condition
	always @(posedge aclk) begin
		if (!aresetn) begin
			qual_cnt_reg <= 25'h0000000;
			qualified_reg <= 1'b0;
			held_reg <= 1'b0;
		end else if (!raw_lock) begin
			qual_cnt_reg <= 25'h0000000; // RQ23
			qualified_reg <= 1'b0;
			held_reg <= 1'b0;
		end else begin
			if (qual_cnt_reg == LOCK_QUAL_CYC - 1) begin
				qualified_reg <= 1'b1; // RQ8
			end else begin
				qual_cnt_reg <= qual_cnt_reg + 25'h0000001;
			end
			held_reg <= lock_now; // RQ10
		end
	end

	// ----------------------------------------
	// Lamp and command outputs
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			online_lamp <= 1'b0;
			capstan_ctrl <= 1'b0;
			servo_release <= 1'b0;
			record_tally <= 1'b0;
			rehearse_tally <= 1'b0;
			lock_lamp <= 1'b0;
			err_show_l <= 1'b0;
			resolve_lamp <= 1'b0;
			code_lamps <= 4'h0;
			remote_local_indicator <= 1'b0;
			bandwidth_limit_indicator <= 1'b0;
			varispeed_indicator <= 1'b0;
			speed_lamps <= 3'h0;
			film_lamp <= 1'b0;
			vitc_lamp <= 1'b0;
			cue_cmd <= 1'b0;
			rewind_cmd <= 1'b0;
			menu_back <= 1'b0;
			cue_prev_reg <= 1'b0;
		end else begin
			online_lamp <= online;
			capstan_ctrl <= online && !(video_s && lock_now); // RQ1 RQ2 RQ9
			servo_release <= online && video_s && lock_now; // RQ9
			record_tally <= recording_s; // RQ4
			rehearse_tally <= rehearse_s; // RQ5
			lock_lamp <= lock_now; // RQ6 RQ23
			err_show_l <= lock_now; // RQ7
			resolve_lamp <= play_s && in_window && (csync_s || held_reg); // RQ11 RQ10
			code_lamps <= onehot(ctype_s) | // RQ15
				((mcode != ctype_s && flash_reg) ? onehot(mcode) : 4'h0); // RQ16
			remote_local_indicator <= serrl_s && (tp_remote_ok(remote_s, flash_reg)); // RQ17
			bandwidth_limit_indicator <= ctrl_reg[`TSI_CTRL_BW_LIMIT]; // RQ18
			varispeed_indicator <= ctrl_reg[`TSI_CTRL_VARISPEED] && online; // RQ19
			speed_lamps <= (speed_s == 2'h3) ? 3'h0 : speed_oh[2:0]; // RQ20
			film_lamp <= film_s; // RQ21
			vitc_lamp <= vitc_s;
			// Key edge and software commands
			cue_prev_reg <= cue_s;
			menu_back <= (cue_s && !cue_prev_reg && setup) || sw_cmd_reg[2]; // RQ14
			rewind_cmd <= !setup && ((cue_s && !cue_prev_reg && shift_s) ||
				sw_cmd_reg[1]); // RQ13 RQ3
			cue_cmd <= !setup && !online && ((cue_s && !cue_prev_reg && !shift_s) ||
				sw_cmd_reg[0]); // RQ12 RQ3
		end
	end

	// Steady in remote, blinking in local
	function tp_remote_ok;
		input rem;
		input fl;
		begin
			tp_remote_ok = rem || fl;
		end
	endfunction

endmodule
`default_nettype wire

// *** verif/tsi_status_monitor.sv ***
// Assertion checker for the status indicator block
`timescale 1ns/1ps
`default_nettype none
module tsi_mon #(parameter LOCK_QUAL_CYC = 8) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tp_recording,
	input wire logic tp_rehearse,
	input wire logic tp_playing,
	input wire logic tp_code_sync,
	input wire logic [1:0] tp_code_type,
	input wire logic online_lamp,
	input wire logic capstan_ctrl,
	input wire logic record_tally,
	input wire logic rehearse_tally,
	input wire logic lock_lamp,
	input wire logic err_show_l,
	input wire logic [3:0] code_lamps,
	input wire logic cue_cmd,
	input wire logic rewind_cmd
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic lk1_reg, lk2_reg;
	logic [31:0] run_reg;
	// Raw lock at the pins seen through two input stages
	always @(posedge aclk) begin
		if (!aresetn) begin
			lk1_reg <= 1'b0;
			lk2_reg <= 1'b0;
		end else begin
			lk1_reg <= tp_playing && tp_code_sync;
			lk2_reg <= lk1_reg;
		end
	end
	// Cycles the raw lock has held
	always @(posedge aclk) begin
		if (!aresetn || !lk2_reg) run_reg <= 32'h0;
		else run_reg <= run_reg + 32'h1;
	end
	property p_record; $rose(tp_recording) |-> ##[2:4] record_tally; endproperty
	a_record: assert property (p_record) else $error("record tally late");
	property p_rehearse; $fell(tp_rehearse) |-> ##[2:4] !rehearse_tally; endproperty
	a_rehearse: assert property (p_rehearse) else $error("rehearse tally stuck");
	property p_drop; $fell(tp_playing) |-> ##[2:4] !lock_lamp; endproperty
	a_drop: assert property (p_drop) else $error("lock kept after drop");
	property p_errl; lock_lamp |-> err_show_l; endproperty
	a_errl: assert property (p_errl) else $error("letter L missing");
	property p_qual; $rose(lock_lamp) |-> run_reg >= LOCK_QUAL_CYC; endproperty
	a_qual: assert property (p_qual) else $error("lock not qualified");
	property p_off; !online_lamp |-> !capstan_ctrl; endproperty
	a_off: assert property (p_off) else $error("capstan held offline");
	property p_cue; online_lamp |-> !cue_cmd; endproperty
	a_cue: assert property (p_cue) else $error("cue while online");
	property p_code; $stable(tp_code_type)[*6] |-> code_lamps[tp_code_type]; endproperty
	a_code: assert property (p_code) else $error("tape code lamp dark");
	c_lock: cover property ($rose(lock_lamp));
	c_cue: cover property (cue_cmd);
	c_rew: cover property (rewind_cmd);
endmodule
bind tsi_status tsi_mon #(.LOCK_QUAL_CYC(LOCK_QUAL_CYC)) u_mon (.*);
`default_nettype wire

// *** verif/tsi_xport.sv ***
// Transport model: code syncs a while after capstan is driven
`timescale 1ns/1ps
`default_nettype none
module tsi_xport #(parameter SYNC_DLY = 4) (
	input wire logic aclk,
	input wire logic capstan_ctrl,
	input wire logic play_req,
	output logic tp_playing,
	output logic tp_code_sync
);
	logic [7:0] cnt_reg;
	// Play follows request; sync once the capstan pulled it in
	always @(posedge aclk) begin
		tp_playing <= play_req;
		if (!play_req) cnt_reg <= 8'h00;
		else if (capstan_ctrl && cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
		tp_code_sync <= play_req && cnt_reg >= SYNC_DLY;
	end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the status indicator block
`timescale 1ns/1ps
`default_nettype none
`include "tsi_defs.vh"
module tb;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tp_pos_err = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF, code_lamps;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, tp_recording = 1'h0, tp_rehearse = 1'h0, tp_video_type = 1'h0;
	logic tp_serial_rl = 1'h0, tp_remote = 1'h0, film_card = 1'h0, vitc_card = 1'h0;
	logic shift_key = 1'h0, cue_key = 1'h0, play_req = 1'h0;
	logic [1:0] tp_code_type = 2'h0, tp_speed = 2'h0, s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tp_playing;
	logic tp_code_sync, online_lamp, capstan_ctrl, servo_release, record_tally, rehearse_tally;
	logic lock_lamp, err_show_l, resolve_lamp, remote_local_indicator, film_lamp, vitc_lamp;
	logic bandwidth_limit_indicator, varispeed_indicator, cue_cmd, rewind_cmd, menu_back;
	logic [2:0] speed_lamps;
	int fails = 0, checks_done = 0, cue_n = 0, rew_n = 0, menu_n = 0, f0, fr, fd;
	always #20 aclk = ~aclk;
	// Count command pulses
	always @(negedge aclk) begin
		cue_n += (cue_cmd === 1'h1);
		rew_n += (rewind_cmd === 1'h1);
		menu_n += (menu_back === 1'h1);
	end
	tsi_status #(.LOCK_QUAL_CYC(8), .FLASH_CYC(4)) DUT (.*);
	tsi_xport #(.SYNC_DLY(4)) u_tp (.aclk(aclk), .capstan_ctrl(capstan_ctrl),
		.play_req(play_req), .tp_playing(tp_playing), .tp_code_sync(tp_code_sync));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic conclude;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// One AXI4-Lite write or read, each channel held until taken
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic ra, rw;
		rs = 2'h3;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_arvalid <= !wr;
		s_axi_bready <= wr;
		s_axi_rready <= !wr;
		while (rs === 2'h3) begin
			@(negedge aclk);
			ra = wr ? s_axi_awready : s_axi_arready;
			rw = s_axi_wready;
			if (wr && s_axi_bvalid === 1'h1) rs = s_axi_bresp;
			if (!wr && s_axi_rvalid === 1'h1) rs = s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge aclk);
			if (ra === 1'h1 && wr) s_axi_awvalid <= 1'h0;
			if (rw === 1'h1) s_axi_wvalid <= 1'h0;
			if (ra === 1'h1 && !wr) s_axi_arvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic key(input logic s);
		shift_key <= s;
		cue_key <= 1'h1;
		cyc(5);
		cue_key <= 1'h0;
		shift_key <= 1'h0;
		cyc(5);
	endtask
	initial begin
		repeat (4000) @(posedge aclk);
		fails++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		bus(0, `TSI_CTRL_ADDR, 0);
		chk(rd, `TSI_CTRL_RESET);
		bus(0, 8'h10, 0);
		chk(rs, 2'h2);
		chk(rd, 32'h0);
		tp_recording <= 1'h1;
		cyc(6);
		chk({record_tally, rehearse_tally}, 2'h2);
		tp_recording <= 1'h0;
		tp_rehearse <= 1'h1;
		cyc(6);
		chk({record_tally, rehearse_tally}, 2'h1);
		tp_rehearse <= 1'h0;
		bus(1, `TSI_CTRL_ADDR, 32'h1);
		cyc(2);
		chk({rs, online_lamp, capstan_ctrl}, 4'h3);
		play_req <= 1'h1;
		cyc(10);
		chk(lock_lamp, 0);
		cyc(20);
		chk({lock_lamp, err_show_l, resolve_lamp}, 3'h7);
		tp_pos_err <= 8'h19;
		cyc(6);
		chk({lock_lamp, resolve_lamp}, 2'h3);
		tp_pos_err <= 8'h1A;
		cyc(6);
		chk({lock_lamp, resolve_lamp}, 2'h0);
		tp_pos_err <= 8'h00;
		play_req <= 1'h0;
		cyc(6);
		chk(lock_lamp, 0);
		tp_video_type <= 1'h1;
		play_req <= 1'h1;
		cyc(30);
		chk({lock_lamp, servo_release, capstan_ctrl}, 3'h6);
		play_req <= 1'h0;
		tp_video_type <= 1'h0;
		key(0);
		chk(cue_n, 0);
		key(1);
		chk(rew_n, 1);
		bus(1, `TSI_CTRL_ADDR, 32'h0);
		cyc(2);
		chk({online_lamp, capstan_ctrl}, 2'h0);
		key(0);
		chk(cue_n, 1);
		bus(1, `TSI_CMD_ADDR, 32'h2);
		cyc(2);
		chk(rew_n, 2);
		bus(1, `TSI_CTRL_ADDR, 32'h2);
		key(0);
		chk({menu_n[3:0], cue_n[3:0]}, 8'h11);
		for (int i = 0; i < 4; i++) begin
			tp_code_type <= i[1:0];
			bus(1, `TSI_CTRL_ADDR, i << 4);
			cyc(6);
			chk(code_lamps, 4'h1 << i);
		end
		tp_serial_rl <= 1'h1;
		bus(1, `TSI_CTRL_ADDR, 32'h0);
		cyc(4);
		f0 = 0;
		fr = 0;
		fd = 0;
		repeat (32) begin
			@(posedge aclk);
			f0 += code_lamps[0];
			fr += remote_local_indicator;
			fd += (code_lamps[0] != remote_local_indicator);
		end
		chk({f0 > 0 && f0 < 32, code_lamps[3]}, 2'h3);
		chk(fr > 0 && fr < 32, 1);
		chk(fd, 0);
		tp_remote <= 1'h1;
		cyc(6);
		chk(remote_local_indicator, 1);
		cyc(4);
		chk(remote_local_indicator, 1);
		bus(1, `TSI_CTRL_ADDR, 32'hD);
		cyc(2);
		chk({bandwidth_limit_indicator, varispeed_indicator}, 2'h3);
		for (int i = 0; i < 3; i++) begin
			tp_speed <= i[1:0];
			cyc(6);
			chk(speed_lamps, 3'h1 << i);
		end
		film_card <= 1'h1;
		cyc(6);
		chk({film_lamp, vitc_lamp}, 2'h2);
		film_card <= 1'h0;
		vitc_card <= 1'h1;
		cyc(6);
		chk({film_lamp, vitc_lamp}, 2'h1);
		conclude();
	end
endmodule
`default_nettype wire
